/* File: core/sca_agent_responder.v */
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "sca_regs.vh"
// Operation
// R01 - four agent windows, 20h apart, at base
// R02 - base held in quadlets, times four
// R03 - orb write in reset/suspended: load, fetch
// R04 - active orb write conflicts; dead ignores
// R05 - doorbell write sets doorbell flag always
// R06 - suspended doorbell refetches if enabled
// R07 - unsolicited write sets enable flag
// R08 - agent state write is type error
// R09 - agent reset write returns to reset
// R10 - success ack complete or pending by select
// R11 - two selects choose error handling
// R12 - store select: ack complete, store packet
// R13 - packet select: pending, error response
// R14 - neither select: error ack, no response
// R15 - write-only registers read as type error
// R16 - state/pointer reads pending plus data
// R17 - reserved area pending, stored for firmware
// R18 - dummy next address suspends, no fetch
module sca_agent_responder #(
  parameter BASE_W = 13
) (
  // clock, reset, enable
  input wire sys_clk,
  input wire arst_n,
  input wire clkEn,
  // incoming request from link (same clock)
  input wire reqValid,
  input wire reqWrite,
  input wire [47:0] reqAddr,
  input wire [31:0] reqData,
  // fetched orb next address from link
  input wire nextValid,
  input wire [1:0] nextAgent,
  input wire [63:0] nextAddr,
  // acknowledge and response
  output reg ackValid,
  output reg [3:0] ackCode,
  output reg respValid,
  output reg [3:0] respCode,
  output reg [31:0] respData,
  // command transmit queue and receive fifo
  output reg fetchValid,
  output reg [1:0] fetchAgent,
  output reg [63:0] fetchAddr,
  output reg storeValid,
  output reg [47:0] storeAddr,
  output reg [31:0] storeData,
  // axi4-lite slave
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  output reg irq
);
  // ******************************
  // state
  // ******************************
  reg [31:0] cfg;
  reg [3:0] evStatus;
  reg [3:0] evMask;
  reg [1:0] agState [0:3];
  reg [31:0] orbHi [0:3];
  reg [31:0] orbLo [0:3];
  reg [3:0] doorbellFlag;
  reg [3:0] unsolicitedFlag;
  reg [7:0] awA;
  reg [31:0] wD;
  reg awHave;
  reg wHave;
  reg [1:0] dbgAgent;
  integer i;

  // ******************************
  // decode
  // ******************************
  wire [47:0] baseByte = {{(48-BASE_W-2){1'b0}}, cfg[`SCA_CFG_BASE_LSB +: BASE_W], 2'b00}; // [R02]
  wire [47:0] rel = reqAddr - baseByte;
  wire inWin = (reqAddr >= baseByte) && (rel < 48'h0000_0000_0080); // [R01]
  wire [1:0] ag = rel[6:5]; // [R01]
  wire [4:0] off = rel[4:0];
  wire [1:0] st = agState[ag];
  wire isState = off == `SCA_OFF_STATE;
  wire isRst = off == `SCA_OFF_RESET;
  wire isOrb = off == `SCA_OFF_ORBHI || off == `SCA_OFF_ORBLO;
  wire isDb = off == `SCA_OFF_DOORBELL;
  wire isUn = off == `SCA_OFF_UNSOL;
  wire isRsv = !(isState || isRst || isOrb || isDb || isUn);
  wire [3:0] okAck = cfg[`SCA_CFG_ACKPEND] ? `SCA_ACK_PENDING : `SCA_ACK_COMPLETE; // [R10]
  wire errPkt = cfg[`SCA_CFG_ERRPKT];
  wire errStore = cfg[`SCA_CFG_ERRSTORE];
  // error classification
  wire typeErr = reqWrite ? isState : (isRst || isDb || isUn); // [R08] [R15]
  wire conflictErr = reqWrite && isOrb && st == `SCA_ST_ACTIVE; // [R04]
  wire anyErr = typeErr || conflictErr;
  wire take = clkEn && reqValid && inWin;
  wire [3:0] evSet;
  // a dummy lo write suspends and fetches nothing, so it must not flag a fetch
  assign evSet[`SCA_EV_FETCH] = take && reqWrite && !anyErr && ((isOrb && off == `SCA_OFF_ORBLO &&
    (st == `SCA_ST_RESET || st == `SCA_ST_SUSPENDED) &&
    !(orbHi[ag] == `SCA_DUMMY_HI && reqData == `SCA_DUMMY_LO)) || // [R18]
    (isDb && st == `SCA_ST_SUSPENDED && cfg[`SCA_CFG_DBFETCH]));
  assign evSet[`SCA_EV_STORE] = take && (isRsv || (anyErr && !errPkt && errStore));
  assign evSet[`SCA_EV_DOORBELL] = take && reqWrite && isDb;
  assign evSet[`SCA_EV_ERROR] = take && anyErr;

  // ******************************
  // request handling
  // ******************************
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ackValid <= 1'b0;
      ackCode <= 4'h0;
      respValid <= 1'b0;
      respCode <= 4'h0;
      respData <= 32'h0000_0000;
      fetchValid <= 1'b0;
      fetchAgent <= 2'h0;
      fetchAddr <= 64'h0000_0000_0000_0000;
      storeValid <= 1'b0;
      storeAddr <= 48'h0000_0000_0000;
      storeData <= 32'h0000_0000;
      doorbellFlag <= 4'h0;
      unsolicitedFlag <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        agState[i] <= `SCA_ST_RESET;
        orbHi[i] <= 32'h0000_0000;
        orbLo[i] <= 32'h0000_0000;
      end
    end else if (clkEn) begin
      ackValid <= 1'b0;
      respValid <= 1'b0;
      fetchValid <= 1'b0;
      storeValid <= 1'b0;
      if (nextValid) begin
        if (nextAddr[63:32] == `SCA_DUMMY_HI && nextAddr[31:0] == `SCA_DUMMY_LO) begin
          agState[nextAgent] <= `SCA_ST_SUSPENDED; // [R18]
        end else if (agState[nextAgent] == `SCA_ST_ACTIVE) begin
          fetchValid <= 1'b1;
          fetchAgent <= nextAgent;
          fetchAddr <= nextAddr;
          orbHi[nextAgent] <= nextAddr[63:32];
          orbLo[nextAgent] <= nextAddr[31:0];
        end
      end
      if (take) begin
        ackValid <= 1'b1;
        if (isRsv) begin
          ackCode <= `SCA_ACK_PENDING; // [R17]
          storeValid <= 1'b1;
          storeAddr <= reqAddr;
          storeData <= reqData;
        end else if (anyErr) begin
          if (!errPkt && errStore) begin
            ackCode <= `SCA_ACK_COMPLETE; // [R11] [R12]
            storeValid <= 1'b1;
            storeAddr <= reqAddr;
            storeData <= reqData;
          end else if (errPkt && !errStore) begin
            ackCode <= `SCA_ACK_PENDING; // [R13]
            respValid <= 1'b1;
            respCode <= conflictErr ? `SCA_RESP_CONFLICT : `SCA_RESP_TYPE;
            respData <= 32'h0000_0000;
          end else begin
            ackCode <= conflictErr ? `SCA_ACK_CONFLICT : `SCA_ACK_TYPE; // [R14]
          end
        end else if (!reqWrite) begin
          ackCode <= `SCA_ACK_PENDING; // [R16]
          respValid <= 1'b1;
          respCode <= `SCA_RESP_COMPLETE;
          respData <= isState ? {30'h0000_0000, st} :
            (off == `SCA_OFF_ORBHI ? orbHi[ag] : orbLo[ag]);
        end else begin
          ackCode <= okAck; // [R10]
          if (isRst && st != `SCA_ST_RESET) begin
            agState[ag] <= `SCA_ST_RESET; // [R09]
          end
          if (isDb) begin
            doorbellFlag[ag] <= 1'b1; // [R05]
            if (st == `SCA_ST_SUSPENDED && cfg[`SCA_CFG_DBFETCH]) begin
              fetchValid <= 1'b1; // [R06]
              fetchAgent <= ag;
              fetchAddr <= {orbHi[ag], orbLo[ag]};
            end
          end
          if (isUn) begin
            unsolicitedFlag[ag] <= 1'b1; // [R07]
          end
          if (isOrb && (st == `SCA_ST_RESET || st == `SCA_ST_SUSPENDED)) begin
            if (off == `SCA_OFF_ORBHI) begin
              orbHi[ag] <= reqData; // [R03]
            end else begin
              orbLo[ag] <= reqData; // [R03]
              if (orbHi[ag] == `SCA_DUMMY_HI && reqData == `SCA_DUMMY_LO) begin
                agState[ag] <= `SCA_ST_SUSPENDED; // [R18]
              end else begin
                agState[ag] <= `SCA_ST_ACTIVE;
                fetchValid <= 1'b1; // [R03]
                fetchAgent <= ag;
                fetchAddr <= {orbHi[ag], reqData};
              end
            end
          end
        end
      end
      // firmware clears flags; a set in the same cycle wins
      if (awHave && wHave && !bvalid && awA == `SCA_AXI_AGENT) begin
        doorbellFlag <= (doorbellFlag & ~wD[3:0]) |
          ((take && reqWrite && isDb) ? (4'h1 << ag) : 4'h0);
        unsolicitedFlag <= (unsolicitedFlag & ~wD[7:4]) |
          ((take && reqWrite && isUn) ? (4'h1 << ag) : 4'h0);
        for (i = 0; i < 4; i = i + 1) begin
          if (wD[8 + i] && !(take && ag == i)) begin
            agState[i] <= `SCA_ST_DEAD;
          end
        end
      end
    end
  end

  // ******************************
  // axi4-lite slave
  // ******************************
  wire wrGo = awHave && wHave && !bvalid;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      awready <= 1'b0;
      wready <= 1'b0;
      awHave <= 1'b0;
      wHave <= 1'b0;
      awA <= 8'h00;
      wD <= 32'h0000_0000;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= 2'b00;
      rdata <= 32'h0000_0000;
      cfg <= `SCA_CFG_RESET;
      evStatus <= 4'h0;
      evMask <= 4'h0;
      irq <= 1'b0;
      dbgAgent <= 2'h0;
    end else if (clkEn) begin
      awready <= !awHave && !awready && awvalid;
      wready <= !wHave && !wready && wvalid;
      if (awvalid && awready) begin
        awHave <= 1'b1;
        awA <= awaddr;
      end
      if (wvalid && wready) begin
        wHave <= 1'b1;
        wD <= wdata;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      evStatus <= evStatus | evSet;
      if (wrGo) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        bvalid <= 1'b1;
        bresp <= 2'b00;
        case (awA)
          `SCA_AXI_CFG: cfg <= wD;
          `SCA_AXI_STATUS: evStatus <= (evStatus & ~wD[3:0]) | evSet;
          `SCA_AXI_MASK: evMask <= wD[3:0];
          `SCA_AXI_AGENT: dbgAgent <= wD[17:16];
          default: bresp <= 2'b10;
        endcase
      end
      irq <= |(evStatus & evMask);
      arready <= !arready && !rvalid && arvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= 2'b00;
        case (araddr)
          `SCA_AXI_CFG: rdata <= cfg;
          `SCA_AXI_STATUS: rdata <= {28'h000_0000, evStatus};
          `SCA_AXI_MASK: rdata <= {28'h000_0000, evMask};
          `SCA_AXI_AGENT: rdata <= {14'h0000, dbgAgent, agState[3], agState[2], agState[1], agState[0],
            unsolicitedFlag, doorbellFlag};
          `SCA_AXI_ORBHI: rdata <= orbHi[dbgAgent];
          `SCA_AXI_ORBLO: rdata <= orbLo[dbgAgent];
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= 2'b10;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

/* File: shared/sca_regs.vh */
`ifndef SCA_REGS_VH
`define SCA_REGS_VH
// agent register offsets inside one 32-byte agent window
`define SCA_OFF_STATE 5'h00
`define SCA_OFF_RESET 5'h04
`define SCA_OFF_ORBHI 5'h08
`define SCA_OFF_ORBLO 5'h0C
`define SCA_OFF_DOORBELL 5'h10
`define SCA_OFF_UNSOL 5'h14
`define SCA_AGENT_SPAN 8'h20
`define SCA_NUM_AGENTS 4
// agent states as read back
`define SCA_ST_RESET 2'h0
`define SCA_ST_ACTIVE 2'h1
`define SCA_ST_SUSPENDED 2'h2
`define SCA_ST_DEAD 2'h3
// acknowledge codes
`define SCA_ACK_COMPLETE 4'h1
`define SCA_ACK_PENDING 4'h2
`define SCA_ACK_CONFLICT 4'h4
`define SCA_ACK_TYPE 4'h6
// response codes
`define SCA_RESP_COMPLETE 4'h0
`define SCA_RESP_CONFLICT 4'h4
`define SCA_RESP_TYPE 4'h6
// axi-lite map
`define SCA_AXI_CFG 8'h00
`define SCA_AXI_STATUS 8'h04
`define SCA_AXI_MASK 8'h08
`define SCA_AXI_AGENT 8'h0C
`define SCA_AXI_ORBHI 8'h10
`define SCA_AXI_ORBLO 8'h14
// cfg bits
`define SCA_CFG_ACKPEND 18
`define SCA_CFG_ERRPKT 15
`define SCA_CFG_ERRSTORE 14
`define SCA_CFG_DBFETCH 0
`define SCA_CFG_BASE_LSB 19
`define SCA_CFG_RESET 32'h0000_0000
// status event bits
`define SCA_EV_FETCH 0
`define SCA_EV_STORE 1
`define SCA_EV_DOORBELL 2
`define SCA_EV_ERROR 3
`define SCA_DUMMY_HI 32'hFFFF_FFFF
`define SCA_DUMMY_LO 32'hFFFF_FFFF
`endif

/* File: testbench/sca_agent_responder_properties.sv */
`timescale 1ns/1ps
`include "sca_regs.vh"
// ****************
// checker
// ****************
module sca_agent_responder_properties #(
  parameter BASE_W = 13
) (
  // clock, reset
  input wire sys_clk,
  input wire arst_n,
  // request side
  input wire clkEn,
  input wire reqValid,
  // answers
  input wire ackValid,
  input wire [3:0] ackCode,
  input wire respValid,
  input wire fetchValid,
  input wire [63:0] fetchAddr,
  input wire storeValid,
  // axi responses
  input wire bvalid,
  input wire bready,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_err;
    ackValid && (ackCode == `SCA_ACK_TYPE || ackCode == `SCA_ACK_CONFLICT);
  endsequence
  sequence s_quiet;
    !fetchValid && !respValid && !storeValid;
  endsequence
  a_ack_cause: assert property (ackValid |-> $past(reqValid && clkEn))
    else $error("ack without request");
  a_ack_single: assert property (ackValid && !reqValid |=> !ackValid)
    else $error("ack longer than one cycle");
  a_resp_pend: assert property (respValid |-> ackValid && ackCode == `SCA_ACK_PENDING)
    else $error("response without pending ack");
  a_error_quiet: assert property (s_err |-> s_quiet)
    else $error("error ack with side effect");
  a_store_acked: assert property (storeValid |-> ackValid && !ackCode[2])
    else $error("store without good ack");
  a_fetch_real: assert property (fetchValid |-> fetchAddr != {`SCA_DUMMY_HI, `SCA_DUMMY_LO})
    else $error("dummy address fetched");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule

bind sca_agent_responder sca_agent_responder_properties #(.BASE_W(BASE_W)) sca_props_inst (
  .sys_clk, .arst_n, .clkEn, .reqValid, .ackValid, .ackCode, .respValid, .fetchValid,
  .fetchAddr, .storeValid, .bvalid, .bready, .rvalid, .rready, .rdata);

/* File: testbench/sca_agent_responder_test.sv */
`timescale 1ns/1ps
`include "sca_regs.vh"
// ****************
// bench
// ****************
module sca_agent_responder_test;
  localparam [12:0] BASE = 13'h0100;
  localparam [47:0] BB = 48'h0000_0000_0400;
  localparam [3:0] AC = `SCA_ACK_COMPLETE, AP = `SCA_ACK_PENDING, AK = `SCA_ACK_CONFLICT, AT = `SCA_ACK_TYPE;
  reg sys_clk = 1'b0, arst_n = 1'b0, clkEn = 1'b1;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0, d, h, l, rnd = 32'h0000_1CE9;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg [1:0] r;
  reg [76:0] ex, exq[$];
  integer n_errors = 0, compares = 0, i;
  wire reqValid, reqWrite, nextValid, ackValid, respValid, fetchValid, storeValid;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [47:0] reqAddr;
  wire [31:0] reqData, respData, rdata;
  wire [1:0] nextAgent, bresp, rresp;
  wire [63:0] nextAddr, fetchAddr;
  wire [3:0] ackCode, respCode;
  sca_initiator_model sca_initiator_model_inst (.sys_clk, .reqValid, .reqWrite, .reqAddr, .reqData,
    .nextValid, .nextAgent, .nextAddr);
  sca_agent_responder sca_agent_responder_inst (.sys_clk, .arst_n, .clkEn, .reqValid, .reqWrite,
    .reqAddr, .reqData, .nextValid, .nextAgent, .nextAddr, .ackValid, .ackCode, .respValid, .respCode,
    .respData, .fetchValid, .fetchAgent(), .fetchAddr, .storeValid, .storeAddr(), .storeData(), .awaddr,
    .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task chk(input [76:0] seen, input [76:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // note f = {resp, fetch, store, check data}
  task rq(input w, input [1:0] ag, input [4:0] o, input [31:0] dt, input [3:0] ac, rc, f, input [63:0] e);
    exq.push_back({1'b1, ac, f[3], rc, f[2:0], e});
    sca_initiator_model_inst.req(w, BB + 48'({ag, o}), dt);
  endtask
  task axw(input [7:0] a, input [31:0] dt);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task axr(input [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // results are checked against the oldest note
  always @(posedge sys_clk) begin
    if (ackValid === 1'b1 || fetchValid === 1'b1) begin
      ex = exq.size() ? exq.pop_front() : '1;
      chk({ackValid, ackValid ? ackCode : 4'h0, respValid, respValid ? respCode : 4'h0, fetchValid, storeValid,
        ex[64], ex[64] ? (fetchValid ? fetchAddr : {32'h0, respData}) : ex[63:0]}, ex);
    end
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    rnd = lfsr(rnd);
    h = rnd;
    rnd = lfsr(rnd);
    l = rnd;
    axw(`SCA_AXI_CFG, {BASE, 19'h0_0001});
    axr(`SCA_AXI_CFG);
    chk(d, {BASE, 19'h0_0001});
    axr(8'h1C);
    chk(r, 2'b10);
    rq(1, 0, `SCA_OFF_ORBHI, h, AC, 0, 0, 0);
    rq(1, 0, `SCA_OFF_ORBLO, l, AC, 0, 5, {h, l});
    rq(1, 0, `SCA_OFF_ORBLO, l, AK, 0, 0, 0);
    rq(0, 0, `SCA_OFF_ORBHI, 0, AP, `SCA_RESP_COMPLETE, 9, {32'h0, h});
    rq(0, 0, `SCA_OFF_STATE, 0, AP, `SCA_RESP_COMPLETE, 9, 64'(`SCA_ST_ACTIVE));
    rq(0, 0, `SCA_OFF_DOORBELL, 0, AT, 0, 0, 0);
    rq(1, 0, `SCA_OFF_STATE, 0, AT, 0, 0, 0);
    rq(0, 0, 5'h18, 0, AP, 0, 2, 0);
    rq(1, 0, 5'h1C, l, AP, 0, 2, 0);
    exq.push_back({9'h0, 4'h5, h, ~l});
    sca_initiator_model_inst.nxt(0, {h, ~l});
    sca_initiator_model_inst.nxt(0, '1);
    rq(1, 0, `SCA_OFF_ORBLO, l, AC, 0, 5, {h, l});
    rq(1, 0, `SCA_OFF_RESET, 0, AC, 0, 0, 0);
    rq(1, 0, `SCA_OFF_ORBLO, l, AC, 0, 5, {h, l});
    sca_initiator_model_inst.nxt(0, '1);
    rq(1, 0, `SCA_OFF_DOORBELL, 0, AC, 0, 5, {h, l});
    axw(`SCA_AXI_AGENT, 32'h0000_0100);
    rq(1, 0, `SCA_OFF_ORBLO, l, AC, 0, 0, 0);
    for (i = 0; i < 4; i++) begin
      rq(1, i[1:0], `SCA_OFF_DOORBELL, 0, AC, 0, 0, 0);
      rq(1, i[1:0], `SCA_OFF_UNSOL, 0, AC, 0, 0, 0);
    end
    sca_initiator_model_inst.req(1, BB + 48'h80, 0);
    axr(`SCA_AXI_AGENT);
    chk(d[7:0], 8'hFF);
    chk(d[15:8], 8'h03);
    // both selects set behaves as neither
    for (i = 1; i < 4; i++) begin
      axw(`SCA_AXI_CFG, {BASE, 19'h0} | (i << 14));
      rq(1, 0, `SCA_OFF_STATE, 0, i == 1 ? AC : i == 2 ? AP : AT, i == 2 ? `SCA_RESP_TYPE : 4'h0,
        i == 1 ? 2 : i == 2 ? 8 : 0, 0);
    end
    axw(`SCA_AXI_CFG, {BASE, 19'h4_0000});
    rq(1, 1, `SCA_OFF_DOORBELL, 0, AP, 0, 0, 0);
    axw(`SCA_AXI_MASK, 32'h0000_000F);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1);
    axw(`SCA_AXI_MASK, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    chk(irq, 0);
    axr(`SCA_AXI_STATUS);
    chk(d[0], 1);
    axw(`SCA_AXI_MASK, 32'h0000_000F);
    axw(`SCA_AXI_STATUS, 32'h0000_000F);
    repeat (3) @(posedge sys_clk);
    chk(irq, 0);
    // frozen clock enable: request must be ignored, no ack, no load
    @(posedge sys_clk);
    clkEn <= 1'b0;
    sca_initiator_model_inst.req(1, BB + 48'h48, ~h);
    repeat (2) @(posedge sys_clk);
    clkEn <= 1'b1;
    axw(`SCA_AXI_AGENT, 32'h0002_0000);
    axr(`SCA_AXI_ORBHI);
    chk(d, 32'h0000_0000);
    chk(exq.size(), 0);
    end_sim;
  end
endmodule

/* File: testbench/sca_initiator_model.sv */
`timescale 1ns/1ps
// ****************
// remote initiator
// ****************
module sca_initiator_model (
  // clock
  input wire sys_clk,
  // request
  output reg reqValid = 1'b0,
  output reg reqWrite = 1'b0,
  output reg [47:0] reqAddr = 48'h0,
  output reg [31:0] reqData = 32'h0,
  // fetched next address
  output reg nextValid = 1'b0,
  output reg [1:0] nextAgent = 2'h0,
  output reg [63:0] nextAddr = 64'h0
);
  // released address and data lines show the inverse, so no stale value passes for a new one
  task req(input w, input [47:0] a, input [31:0] d);
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= a;
    reqData <= d;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    reqAddr <= ~a;
    reqData <= ~d;
  endtask
  task nxt(input [1:0] ag, input [63:0] a);
    @(posedge sys_clk);
    nextValid <= 1'b1;
    nextAgent <= ag;
    nextAddr <= a;
    @(posedge sys_clk);
    nextValid <= 1'b0;
    nextAddr <= ~a;
  endtask
endmodule
